// ---- rtl/paab_pkg.sv ----
// package: constants and types of the start-up sequencer and address allocator
package paab_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_SLOT_SEL = 8'h10;
  localparam logic [7:0] ADDR_SLOT_INFO = 8'h14;
  localparam logic [7:0] ADDR_IMG_SEL = 8'h18;
  localparam logic [7:0] ADDR_IMG_DATA = 8'h1C;
  localparam logic [7:0] ADDR_DIAG = 8'h20;
  // control register fields
  localparam int CTRL_RESET_REQ = 0;
  localparam int CTRL_CYCLE_DONE = 1;
  localparam int CTRL_CFG_VALID = 2;
  // interrupt event bit positions
  localparam int EV_BOOT_DONE = 0;
  localparam int EV_AUTO_RESET = 1;
  localparam int EV_IMG_REFRESH = 2;
  localparam int EV_WIDTH = 3;
  // address allocation figures
  localparam logic [12:0] IO_SPACE_MAX = 13'h1FFF;
  localparam logic [12:0] IMG_TOP = 13'h00FF;
  localparam logic [12:0] STD_DIG_SPAN = 13'h0004;
  localparam logic [12:0] STD_ANA_SPAN = 13'h0010;
  localparam logic [12:0] HS_ANA_SPAN = 13'h0100;
  localparam logic [12:0] STD_ANA_BASE = 13'h0100;
  localparam logic [12:0] HS_DIG_BASE = 13'h0080;
  localparam logic [12:0] HS_ANA_BASE = 13'h0800;
  localparam int HS_SLOT_FIRST = 101;
  localparam int STD_SLOTS = 32;
  localparam int HS_SLOTS = 16;
  localparam int SLOTS = STD_SLOTS + HS_SLOTS;
  localparam int IMG_BYTES = 256;
  // diagnostic event code for unbuffered power-on overall reset
  localparam logic [7:0] DIAG_AUTO_RESET = 8'h01;
  // module kinds reported by each slot
  typedef enum logic [1:0]
  {
    KIND_NONE = 2'h0,
    KIND_DIGITAL = 2'h1,
    KIND_OTHER = 2'h2
  } paab_kind_type;
  // start-up states, one-hot
  typedef enum logic [6:0]
  {
    ST_POWER = 7'h01,
    ST_RESET = 7'h02,
    ST_LOAD_CARD = 7'h04,
    ST_LOAD_PROT = 7'h08,
    ST_ALLOC = 7'h10,
    ST_STOP = 7'h20,
    ST_RUN = 7'h40
  } paab_state_type;
  // allocation result per slot
  typedef struct packed
  {
    logic [12:0] start;
    logic [8:0] span;
  } paab_alloc_type;
  // loader handshake
  typedef struct packed
  {
    logic card;
    logic prot;
  } paab_load_type;
endpackage : paab_pkg

// ---- rtl/paab_boot.sv ----
// start-up sequencer, automatic address allocator and process images
//
// Notes on behaviour
// - at power-on enter the state the run/stop lever selects
// - every completed overall reset loads the program from the memory card when one is present
// - factory-reset device with no program runs empty on stop-to-run
// - valid battery memory at start-up runs the retained program
// - lost battery memory at power-on forces an overall reset first
// - during that reset a present memory card is loaded into work memory
// - without card, stored protected blocks are loaded if any exist
// - after reset and load, lever chooses run or stop
// - the automatic reset is logged in the diagnostic event buffer
// - digital modules get addresses from 0 rising with slot
// - analog modules without configuration sit at even addresses from 256
// - address space 0 to 8191, images cover 0 to 255
// - lowest addresses are mirrored into an input and an output image
// - both images refresh when a program cycle completes
// - 32 standard-bus modules and 16 high-speed modules are supported
// - automatic allocation only without configuration; configured address wins
// - digital takes 4 bytes, others 16 standard or 256 high-speed
// - start addresses follow the per-bus slot formulas
`timescale 1ns/10ps
module paab_boot
  import paab_pkg::*;
#(
  parameter int SLOT_COUNT = paab_pkg::SLOTS
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins from the device
  input wire logic run_lever,
  input wire logic battery_valid,
  input wire logic card_present,
  input wire logic prot_present,
  input wire logic program_present,
  // slot kinds and configured addresses
  input wire logic [2*paab_pkg::SLOTS-1:0] slot_kind,
  input wire logic [13*paab_pkg::SLOTS-1:0] cfg_addr,
  // loader
  output paab_pkg::paab_load_type load_req,
  input wire logic load_done,
  // process image feed
  input wire logic [7:0] io_in_byte,
  output logic [7:0] img_addr,
  output logic [7:0] io_out_byte,
  output logic io_out_we,
  // status
  output logic run_mode,
  output logic irq
);
  import paab_pkg::*;

  // three-flop pin synchronisers; a change counts once stages two and three agree
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] pins;
  wire [4:0] pin_raw = {program_present, prot_present, card_present, battery_valid, run_lever};
  always_ff @(posedge ref_clk)
  begin
    sync1 <= pin_raw;
    sync2 <= sync1;
    sync3 <= sync2;
  end
  genvar gp;
  generate
    for (gp = 0; gp < 5; gp++)
    begin : g_pin
      always_ff @(posedge ref_clk)
      begin
        if (reset)
          pins[gp] <= sync3[gp]; // settles while reset is held, so power-on sees the real pin
        else if (sync2[gp] == sync3[gp])
          pins[gp] <= sync3[gp];
      end
    end
  endgenerate
  wire lever = pins[0];
  wire batt_ok = pins[1];
  wire card_in = pins[2];
  wire prot_in = pins[3];
  wire prog_ok = pins[4];

  // bus address phase capture
  logic wr_pend;
  logic rd_pend;
  logic [7:0] reg_addr;
  wire bus_take = hsel && hready && htrans[1];
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      reg_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= bus_take && hwrite;
      rd_pend <= bus_take && !hwrite;
      if (bus_take)
        reg_addr <= haddr[7:0];
    end
  end

  // write strobes per register
  wire wr_ctrl = wr_pend && (reg_addr == ADDR_CTRL);
  wire wr_istat = wr_pend && (reg_addr == ADDR_IRQ_STAT);
  wire wr_imask = wr_pend && (reg_addr == ADDR_IRQ_MASK);
  wire wr_slot = wr_pend && (reg_addr == ADDR_SLOT_SEL);
  wire wr_isel = wr_pend && (reg_addr == ADDR_IMG_SEL);
  wire wr_idata = wr_pend && (reg_addr == ADDR_IMG_DATA);
  wire reset_req = wr_ctrl && hwdata[CTRL_RESET_REQ];
  wire cycle_done = wr_ctrl && hwdata[CTRL_CYCLE_DONE];

  // configuration flag and selectors
  logic cfg_valid;
  logic [5:0] slot_sel;
  logic [8:0] img_sel;
  logic [EV_WIDTH-1:0] irq_mask;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cfg_valid <= 1'b0;
      slot_sel <= 6'h00;
      img_sel <= 9'h000;
      irq_mask <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        cfg_valid <= hwdata[CTRL_CFG_VALID];
      if (wr_slot)
        slot_sel <= hwdata[5:0];
      if (wr_isel)
        img_sel <= hwdata[8:0];
      if (wr_imask)
        irq_mask <= hwdata[EV_WIDTH-1:0];
    end
  end

  // start-up sequencer
  paab_state_type state;
  paab_state_type next_state;
  logic auto_reset;
  logic [5:0] alloc_idx;
  wire alloc_last = (alloc_idx == 6'(SLOT_COUNT - 1));
  always_comb
  begin
    next_state = state;
    case (state)
      ST_POWER:
        if (!batt_ok)
          next_state = ST_RESET;
        else
          next_state = ST_ALLOC;
      ST_RESET:
        if (card_in)
          next_state = ST_LOAD_CARD;
        else if (prot_in)
          next_state = ST_LOAD_PROT;
        else
          next_state = ST_ALLOC;
      ST_LOAD_CARD, ST_LOAD_PROT:
        if (load_done)
          next_state = ST_ALLOC;
      ST_ALLOC:
        if (alloc_last)
          next_state = lever ? ST_RUN : ST_STOP;
      ST_STOP:
        if (reset_req)
          next_state = ST_RESET;
        else if (lever)
          next_state = ST_RUN;
      ST_RUN:
        if (reset_req)
          next_state = ST_RESET;
        else if (!lever)
          next_state = ST_STOP;
      default:
        next_state = ST_POWER;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state <= ST_POWER;
      auto_reset <= 1'b0;
      alloc_idx <= 6'h00;
    end
    else
    begin
      state <= next_state;
      if (state == ST_POWER)
        auto_reset <= !batt_ok;
      else if (state == ST_ALLOC && alloc_last)
        auto_reset <= 1'b0;
      alloc_idx <= (state == ST_ALLOC) ? alloc_idx + 6'h01 : 6'h00;
    end
  end

  // loader request and run flag, all registered
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      load_req <= '0;
      run_mode <= 1'b0;
    end
    else
    begin
      load_req.card <= (next_state == ST_LOAD_CARD);
      load_req.prot <= (next_state == ST_LOAD_PROT);
      run_mode <= (next_state == ST_RUN);
    end
  end

  // allocation: one slot per cycle, results held until the next pass
  paab_alloc_type alloc [SLOT_COUNT];
  wire is_hs = (alloc_idx >= 6'(STD_SLOTS));
  wire [12:0] pos = is_hs ? 13'(alloc_idx - 6'(STD_SLOTS)) : 13'(alloc_idx);
  wire [1:0] kind = slot_kind[2*alloc_idx +: 2];
  wire [12:0] cfg_one = cfg_addr[13*alloc_idx +: 13];
  wire [12:0] dig_start = (pos << 2) + (is_hs ? HS_DIG_BASE : 13'h0000);
  wire [12:0] ana_start = is_hs ? 13'((pos << 8) + HS_ANA_BASE)
                                : 13'((pos << 4) + STD_ANA_BASE);
  wire [8:0] dig_span = 9'(STD_DIG_SPAN);
  wire [8:0] ana_span = is_hs ? 9'(HS_ANA_SPAN) : 9'(STD_ANA_SPAN);
  wire [12:0] auto_start = (kind == KIND_DIGITAL) ? dig_start : ana_start;
  wire [8:0] auto_span = (kind == KIND_DIGITAL) ? dig_span :
                         (kind == KIND_NONE) ? 9'h000 : ana_span;
  wire [12:0] pick_start = cfg_valid ? cfg_one : auto_start;
  always_ff @(posedge ref_clk)
  begin
    if (state == ST_ALLOC)
      alloc[alloc_idx] <= '{start: pick_start & IO_SPACE_MAX, span: auto_span};
  end

  // process images, 256 bytes each
  logic [7:0] in_img [IMG_BYTES];
  logic [7:0] out_img [IMG_BYTES];
  logic refreshing;
  logic [7:0] ref_idx;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      refreshing <= 1'b0;
      ref_idx <= 8'h00;
    end
    else if (cycle_done && run_mode)
    begin
      refreshing <= 1'b1;
      ref_idx <= 8'h00;
    end
    else if (refreshing)
    begin
      ref_idx <= ref_idx + 8'h01;
      refreshing <= (ref_idx != 8'(IMG_TOP));
    end
  end
  // image walk: read input byte, write output byte, addresses 0 to 255 only
  always_ff @(posedge ref_clk)
  begin
    // input byte answers the registered img_addr, so store it against that address
    if (io_out_we)
      in_img[img_addr] <= io_in_byte;
    if (wr_idata && img_sel[8])
      out_img[img_sel[7:0]] <= hwdata[7:0];
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      img_addr <= 8'h00;
      io_out_byte <= 8'h00;
      io_out_we <= 1'b0;
    end
    else
    begin
      img_addr <= ref_idx;
      io_out_byte <= out_img[ref_idx];
      io_out_we <= refreshing;
    end
  end

  // sticky events, write one to clear, set wins
  wire boot_ev = (state == ST_ALLOC) && alloc_last;
  wire refresh_ev = refreshing && (ref_idx == 8'(IMG_TOP));
  wire auto_ev = (state == ST_POWER) && !batt_ok;
  wire [EV_WIDTH-1:0] ev_set = {refresh_ev, auto_ev, boot_ev};
  logic [EV_WIDTH-1:0] irq_stat;
  logic [7:0] diag_code;
  logic [7:0] diag_count;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      irq_stat <= 3'h0;
      irq <= 1'b0;
      diag_code <= 8'h00;
      diag_count <= 8'h00;
    end
    else
    begin
      irq_stat <= (irq_stat & ~(wr_istat ? hwdata[EV_WIDTH-1:0] : 3'h0)) | ev_set;
      irq <= |(irq_stat & irq_mask);
      if (auto_ev)
      begin
        diag_code <= DIAG_AUTO_RESET;
        diag_count <= diag_count + 8'h01;
      end
    end
  end

  // read mux
  paab_alloc_type sel_alloc;
  assign sel_alloc = alloc[slot_sel];
  wire [31:0] status_word = {23'h0, prog_ok, auto_reset, state};
  wire [31:0] slot_word = {10'h0, sel_alloc.span, sel_alloc.start};
  wire [31:0] img_word = {24'h0, img_sel[8] ? out_img[img_sel[7:0]] : in_img[img_sel[7:0]]};
  // decoded from the address phase; a read right behind a write to the same
  // register returns the value before that write
  wire [7:0] rd_addr = haddr[7:0];
  wire [31:0] rd_word =
    (rd_addr == ADDR_CTRL) ? {29'h0, cfg_valid, 2'h0} :
    (rd_addr == ADDR_STATUS) ? status_word :
    (rd_addr == ADDR_IRQ_STAT) ? {29'h0, irq_stat} :
    (rd_addr == ADDR_IRQ_MASK) ? {29'h0, irq_mask} :
    (rd_addr == ADDR_SLOT_SEL) ? {26'h0, slot_sel} :
    (rd_addr == ADDR_SLOT_INFO) ? slot_word :
    (rd_addr == ADDR_IMG_SEL) ? {23'h0, img_sel} :
    (rd_addr == ADDR_IMG_DATA) ? img_word :
    (rd_addr == ADDR_DIAG) ? {16'h0, diag_count, diag_code} : 32'h00000000;
  // zero wait: data appear in the data phase from a flop loaded at the address edge
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (bus_take && !hwrite)
        hrdata <= rd_word;
    end
  end

  // checks
  property p_lost_batt;
    @(posedge ref_clk) disable iff (reset)
      (state == ST_POWER && !batt_ok) |=> (state == ST_RESET);
  endproperty
  a_lost_batt: assert property (p_lost_batt) else $error("no reset on lost battery");
  property p_card;
    @(posedge ref_clk) disable iff (reset)
      (state == ST_RESET && card_in) |=> (state == ST_LOAD_CARD) ##1 load_req.card;
  endproperty
  a_card: assert property (p_card) else $error("card not loaded");
  property p_prot;
    @(posedge ref_clk) disable iff (reset)
      (state == ST_RESET && !card_in && prot_in) |=> (state == ST_LOAD_PROT);
  endproperty
  a_prot: assert property (p_prot) else $error("protected blocks not loaded");
  property p_lever;
    @(posedge ref_clk) disable iff (reset)
      (state == ST_ALLOC && alloc_last) |=> (state == ($past(lever) ? ST_RUN : ST_STOP));
  endproperty
  a_lever: assert property (p_lever) else $error("lever not honoured");
  property p_diag;
    @(posedge ref_clk) disable iff (reset)
      auto_ev |=> (diag_code == DIAG_AUTO_RESET && diag_count == $past(diag_count) + 8'h01);
  endproperty
  a_diag: assert property (p_diag) else $error("auto reset not logged");
  property p_span;
    @(posedge ref_clk) disable iff (reset)
      (state == ST_ALLOC && kind == KIND_OTHER && is_hs) |-> (auto_span == 9'h100);
  endproperty
  a_span: assert property (p_span) else $error("high-speed span wrong");
  property p_start;
    @(posedge ref_clk) disable iff (reset)
      (state == ST_ALLOC && !cfg_valid && kind == KIND_DIGITAL && !is_hs)
        |-> (pick_start == 13'(alloc_idx) * 13'h0004);
  endproperty
  a_start: assert property (p_start) else $error("digital start wrong");
  property p_even;
    @(posedge ref_clk) disable iff (reset)
      (state == ST_ALLOC && !cfg_valid && kind == KIND_OTHER)
        |-> (!pick_start[0] && pick_start >= 13'h0100);
  endproperty
  a_even: assert property (p_even) else $error("analog address odd or low");
  property p_cfg;
    @(posedge ref_clk) disable iff (reset)
      (state == ST_ALLOC && cfg_valid) |-> (pick_start == cfg_one);
  endproperty
  a_cfg: assert property (p_cfg) else $error("configured address ignored");
  property p_refresh;
    @(posedge ref_clk) disable iff (reset)
      (cycle_done && run_mode) |=> refreshing ##1 io_out_we;
  endproperty
  a_refresh: assert property (p_refresh) else $error("image not refreshed");
  c_auto: cover property (@(posedge ref_clk) disable iff (reset) auto_ev);
  c_run: cover property (@(posedge ref_clk) disable iff (reset) state == ST_RUN);
  c_refresh: cover property (@(posedge ref_clk) disable iff (reset) refresh_ev);
endmodule : paab_boot

// ---- test/paab_backplane_model.sv ----
// backplane model: loader answer and process image partner of the start-up block
`timescale 1ns/10ps
module paab_backplane_model
  import paab_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // loader
  input wire paab_pkg::paab_load_type load_req,
  output logic load_done,
  // image walk
  input wire logic [7:0] img_addr,
  input wire logic [7:0] io_out_byte,
  input wire logic io_out_we,
  output logic [7:0] io_in_byte
);
  logic [3:0] wait_cnt = 4'h0;
  logic busy_q = 1'b0;
  int card_loads = 0;
  int prot_loads = 0;
  int out_count = 0;
  logic [7:0] out_img [256];
  initial load_done = 1'b0;
  // input bytes follow the address, so a stale or shifted byte shows up at once
  assign io_in_byte = img_addr ^ 8'h5A;
  // a load is answered once, some cycles late, as a slow card would
  always @(posedge ref_clk)
  begin
    load_done <= 1'b0;
    if (reset)
    begin
      busy_q <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if ((load_req.card || load_req.prot) && !busy_q)
    begin
      busy_q <= 1'b1;
      wait_cnt <= 4'h6;
      card_loads <= card_loads + int'(load_req.card);
      prot_loads <= prot_loads + int'(load_req.prot);
    end
    else if (busy_q && wait_cnt != 4'h0)
    begin
      wait_cnt <= wait_cnt - 4'h1;
      load_done <= (wait_cnt == 4'h1);
    end
    else if (!(load_req.card || load_req.prot))
      busy_q <= 1'b0;
  end
  // output modules latch every byte of the refresh walk
  always @(posedge ref_clk)
  begin
    if (!reset && io_out_we)
    begin
      out_img[img_addr] <= io_out_byte;
      out_count <= out_count + 1;
    end
  end
endmodule : paab_backplane_model

// ---- test/paab_boot_bench.sv ----
// testbench: boot paths, slot allocation, process images and interrupt
`timescale 1ns/10ps
module paab_boot_bench
  import paab_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = 3'h2;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic run_lever = 1'b0;
  logic battery_valid = 1'b0;
  logic card_present = 1'b1;
  logic prot_present = 1'b0;
  logic [2*SLOTS-1:0] slot_kind = '0;
  logic [13*SLOTS-1:0] cfg_addr = '0;
  paab_load_type load_req;
  wire logic load_done;
  wire logic [7:0] io_in_byte;
  logic [7:0] img_addr;
  logic [7:0] io_out_byte;
  logic io_out_we;
  logic run_mode;
  logic irq;
  logic [31:0] rd;
  int err_count = 0;
  int total_checks = 0;
  int i;
  // 25 MHz
  always #20 ref_clk = ~ref_clk;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  paab_boot dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .run_lever(run_lever),
    .battery_valid(battery_valid), .card_present(card_present),
    .prot_present(prot_present), .program_present(1'b0), .slot_kind(slot_kind),
    .cfg_addr(cfg_addr), .load_req(load_req), .load_done(load_done),
    .io_in_byte(io_in_byte), .img_addr(img_addr), .io_out_byte(io_out_byte),
    .io_out_we(io_out_we), .run_mode(run_mode), .irq(irq));
  paab_backplane_model part (.ref_clk(ref_clk), .reset(reset), .load_req(load_req),
    .load_done(load_done), .img_addr(img_addr), .io_out_byte(io_out_byte),
    .io_out_we(io_out_we), .io_in_byte(io_in_byte));
  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // ready and read data are taken at the rising edge, as the bus master does
  task automatic wait_rdy();
    int n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_count++;
        print_verdict();
      end
      @(posedge ref_clk);
    end
    rd = hrdata;
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus
  // polls status until a state among the mask is reached
  task automatic poll(input logic [31:0] m);
    int n = 0;
    do
    begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      n++;
      if (n > 300)
      begin
        err_count++;
        print_verdict();
      end
    end
    while ((|(rd & m)) !== 1'b1);
  endtask : poll
  // waits for irq (sel 1) or run_mode (sel 0) to rise
  task automatic wait_high(input logic sel);
    int n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (n > 800)
      begin
        err_count++;
        print_verdict();
      end
    end
    while ((sel ? irq : run_mode) !== 1'b1);
    @(posedge ref_clk);
  endtask : wait_high
  task automatic boot(input int n, input logic bat, input logic card, input logic prot);
    battery_valid <= bat;
    card_present <= card;
    prot_present <= prot;
    reset <= 1'b1;
    repeat (n) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    poll(32'h60);
  endtask : boot
  // start and span of a slot with kind idx%3, empty slots excluded
  function automatic logic [31:0] exp_info(input int idx);
    logic [12:0] st;
    logic [8:0] sp;
    if (idx % 3 == 1)
    begin
      st = (idx < 32) ? 13'(4 * idx) : 13'(4 * (idx - 32) + 128);
      sp = 9'h004;
    end
    else
    begin
      st = (idx < 32) ? 13'(16 * idx + 256) : 13'(256 * (idx - 32) + 2048);
      sp = (idx < 32) ? 9'h010 : 9'h100;
    end
    return {10'h000, sp, st};
  endfunction : exp_info
  task automatic slot_read(input int idx);
    bus(1'b1, ADDR_SLOT_SEL, 32'(idx));
    bus(1'b0, ADDR_SLOT_INFO, 32'h0);
  endtask : slot_read
  initial
  begin
    for (i = 0; i < SLOTS; i++)
    begin
      slot_kind[2*i +: 2] = 2'(i % 3);
      cfg_addr[13*i +: 13] = 13'h1000 + 13'(i);
    end
    // lost battery, card in, lever at stop
    boot(4, 1'b0, 1'b1, 1'b0);
    check(rd & 32'h7F, 32'h20);
    check({31'h0, run_mode}, 32'h0);
    check({30'h0, hresp, hreadyout}, 32'h1);
    check(32'(part.card_loads), 32'h1);
    bus(1'b0, ADDR_DIAG, 32'h0);
    check(rd & 32'hFFFF, 32'h0101);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    check(rd & 32'h2, 32'h2);
    run_lever <= 1'b1;
    wait_high(1'b0);
    check({31'h0, run_mode}, 32'h1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(rd & 32'h17F, 32'h40);
    for (i = 0; i < SLOTS; i++)
    begin
      slot_read(i);
      if (i % 3 == 0)
        check({23'h0, rd[21:13]}, 32'h0);
      else
        check(rd, exp_info(i));
    end
    // kinds change after start-up, addresses must not follow
    slot_kind <= '1;
    slot_read(2);
    check(rd, exp_info(2));
    for (i = 0; i < SLOTS; i++)
      slot_kind[2*i +: 2] <= 2'(i % 3);
    // output byte 5 set by software, then one program cycle completes
    bus(1'b1, ADDR_IMG_SEL, 32'h105);
    bus(1'b1, ADDR_IMG_DATA, 32'hA5);
    bus(1'b1, ADDR_IRQ_MASK, 32'h4);
    bus(1'b1, ADDR_CTRL, 32'h2);
    wait_high(1'b1);
    check(32'(part.out_count), 32'h100);
    check({24'h0, part.out_img[5]}, 32'hA5);
    bus(1'b1, ADDR_IMG_SEL, 32'h007);
    bus(1'b0, ADDR_IMG_DATA, 32'h0);
    check(rd & 32'hFF, 32'h5D);
    bus(1'b1, ADDR_IMG_SEL, 32'h0FF);
    bus(1'b0, ADDR_IMG_DATA, 32'h0);
    check(rd & 32'hFF, 32'hA5);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h4);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, ADDR_IRQ_STAT, 32'h4);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    // configuration valid plus overall reset request
    bus(1'b1, ADDR_CTRL, 32'h5);
    poll(32'h1F);
    poll(32'h60);
    check(32'(part.card_loads), 32'h2);
    slot_read(2);
    check(rd, {10'h000, 9'h010, 13'h1002});
    // lost battery without card, protected blocks stored
    boot(8, 1'b0, 1'b0, 1'b1);
    check(32'(part.prot_loads), 32'h1);
    check(32'(part.card_loads), 32'h2);
    check(rd & 32'h7F, 32'h40);
    // valid battery: straight to run, nothing loaded
    boot(8, 1'b1, 1'b0, 1'b1);
    check(rd & 32'h7F, 32'h40);
    check(32'(part.prot_loads), 32'h1);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    check(rd & 32'h2, 32'h0);
    print_verdict();
  end
endmodule : paab_boot_bench
